// ===== logic/aag_core.sv
// Accumulator-group execution unit of the small controller CPU
`timescale 1ns/1ps
module aag_core #(
	parameter int CYCLE_CLKS = aag_pkg::INSN_CYCLE_CLKS
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] op_byte,
	input wire logic op_valid,
	input wire logic [7:0] work_reg_n_data,
	input wire logic [7:0] indirect_via_pointer_data,
	output logic [2:0] work_reg_n_sel,
	output logic [7:0] acc,
	output logic carry,
	output logic aux_carry,
	output logic op_taken,
	output logic need_imm,
	output logic pass_on,
	output logic [7:0] pass_op,
	output logic done
);
	// ==========================================================
	// Instruction cycle timing
	typedef enum logic [2:0] {
		AAG_IDLE = 3'b001,
		AAG_IMM = 3'b010,
		AAG_HOLD = 3'b100
	} aag_state_e;

	logic tick;
	aag_state_e state;
	aag_state_e next_state;
	logic [7:0] held_op;
	logic [7:0] next_held_op;
	logic [7:0] next_acc;
	logic next_carry;
	logic next_aux_carry;
	logic next_op_taken;
	logic next_need_imm;
	logic next_pass_on;
	logic [7:0] next_pass_op;
	logic next_done;
	logic [2:0] next_sel;

	aag_cycle_div #(
		.DIV(CYCLE_CLKS)
	) u_div (
		.clk(clk),
		.resetn(resetn),
		.tick(tick)
	);

	// ==========================================================
	// Arithmetic helpers
	function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
		logic [4:0] lo;
		logic [4:0] hi;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
		// Result {carry, aux carry, sum}
		add8 = {hi[4], lo[4], hi[3:0], lo[3:0]};
	endfunction

	// ==========================================================
	// Decode and execute; one op taken per instruction cycle tick
	always_comb begin
		logic [9:0] sum;
		logic [8:0] adj;
		logic [7:0] op;
		logic [7:0] opnd;
		logic use_c;
		sum = 10'h000;
		adj = 9'h000;
		op = op_byte;
		opnd = 8'h00;
		use_c = 1'b0;
		next_state = state;
		next_held_op = held_op;
		next_acc = acc;
		next_carry = carry;
		next_aux_carry = aux_carry;
		next_op_taken = 1'b0;
		next_need_imm = need_imm;
		next_pass_on = 1'b0;
		next_pass_op = pass_op;
		next_done = 1'b0;
		next_sel = op_byte[2:0];
		case (state)
			AAG_IDLE: begin
				if (tick && op_valid) begin
					next_op_taken = 1'b1;
					next_done = 1'b1;
					if (op == aag_pkg::OP_ADD_IMM || op == aag_pkg::OP_ADD_CARRY_IN_IMM
						|| op == aag_pkg::OP_AND_IMM) begin
						// Second byte fetched in the next instruction cycle
						next_held_op = op;
						next_need_imm = 1'b1;
						next_done = 1'b0;
						next_state = AAG_IMM;
					end else if (op[7:3] == aag_pkg::OP_ADD_REG_HI || op[7:3] == aag_pkg::OP_ADD_CARRY_IN_REG_HI) begin
						use_c = (op[7:3] == aag_pkg::OP_ADD_CARRY_IN_REG_HI) & carry;
						sum = add8(acc, work_reg_n_data, use_c);
						{next_carry, next_aux_carry, next_acc} = sum;
					end else if (op[7:1] == aag_pkg::OP_ADD_PTR_HI || op[7:1] == aag_pkg::OP_ADD_CARRY_IN_PTR_HI) begin
						use_c = (op[7:1] == aag_pkg::OP_ADD_CARRY_IN_PTR_HI) & carry;
						sum = add8(acc, indirect_via_pointer_data, use_c);
						{next_carry, next_aux_carry, next_acc} = sum;
					end else if (op[7:3] == aag_pkg::OP_AND_REG_HI) begin
						next_acc = acc & work_reg_n_data;
					end else if (op[7:1] == aag_pkg::OP_AND_PTR_HI) begin
						next_acc = acc & indirect_via_pointer_data;
					end else if (op == aag_pkg::OP_INVERT) begin
						next_acc = ~acc;
					end else if (op == aag_pkg::OP_ZERO) begin
						next_acc = aag_pkg::ACC_RESET;
					end else if (op == aag_pkg::OP_FIXUP) begin
						// Low nibble fixed first, high nibble sees the low step's result
						adj = {1'b0, acc};
						if (aux_carry || acc[3:0] > 4'h9) begin
							adj = {1'b0, acc} + 9'h006;
						end
						if (carry || adj[8] || adj[7:4] > 4'h9) begin
							adj = {adj[8], adj[7:0]} + 9'h060;
							next_carry = 1'b1;
						end
						next_acc = adj[7:0];
					end else if (op == aag_pkg::OP_DEC) begin
						next_acc = acc - 8'h01;
					end else if (op == aag_pkg::OP_INC) begin
						next_acc = acc + 8'h01;
					end else begin
						next_op_taken = 1'b0;
						next_done = 1'b0;
						next_pass_on = 1'b1;
						next_pass_op = op;
					end
				end
			end
			AAG_IMM: begin
				if (tick && op_valid) begin
					opnd = op_byte;
					next_need_imm = 1'b0;
					next_done = 1'b1;
					next_state = AAG_IDLE;
					if (held_op == aag_pkg::OP_AND_IMM) begin
						next_acc = acc & opnd;
					end else begin
						use_c = (held_op == aag_pkg::OP_ADD_CARRY_IN_IMM) & carry;
						sum = add8(acc, opnd, use_c);
						{next_carry, next_aux_carry, next_acc} = sum;
					end
				end
			end
			AAG_HOLD: begin
				next_state = AAG_IDLE;
			end
			default: begin
				next_state = AAG_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= AAG_IDLE;
			held_op <= 8'h00;
			acc <= aag_pkg::ACC_RESET;
			carry <= 1'b0;
			aux_carry <= 1'b0;
			op_taken <= 1'b0;
			need_imm <= 1'b0;
			pass_on <= 1'b0;
			pass_op <= 8'h00;
			done <= 1'b0;
			work_reg_n_sel <= 3'h0;
		end else begin
			state <= next_state;
			held_op <= next_held_op;
			acc <= next_acc;
			carry <= next_carry;
			aux_carry <= next_aux_carry;
			op_taken <= next_op_taken;
			need_imm <= next_need_imm;
			pass_on <= next_pass_on;
			pass_op <= next_pass_op;
			done <= next_done;
			work_reg_n_sel <= next_sel;
		end
	end

	// ==========================================================
	// Checks
	a_inc_wraps: assert property (@(posedge clk) disable iff (!resetn)
		state == AAG_IDLE && tick && op_valid && op_byte == aag_pkg::OP_INC
		|=> acc == $past(acc) + 8'h01 && carry == $past(carry)) else $error("increment wrong");
	a_dec_wraps: assert property (@(posedge clk) disable iff (!resetn)
		state == AAG_IDLE && tick && op_valid && op_byte == aag_pkg::OP_DEC
		|=> acc == $past(acc) - 8'h01 && aux_carry == $past(aux_carry)) else $error("decrement wrong");
	a_zero_acc: assert property (@(posedge clk) disable iff (!resetn)
		state == AAG_IDLE && tick && op_valid && op_byte == aag_pkg::OP_ZERO
		|=> acc == 8'h00 && carry == $past(carry)) else $error("zero_acc wrong");
	a_invert_acc: assert property (@(posedge clk) disable iff (!resetn)
		state == AAG_IDLE && tick && op_valid && op_byte == aag_pkg::OP_INVERT
		|=> acc == ~$past(acc)) else $error("invert_acc wrong");
	a_reg_add: assert property (@(posedge clk) disable iff (!resetn)
		state == AAG_IDLE && tick && op_valid && op_byte[7:3] == aag_pkg::OP_ADD_REG_HI
		|=> {carry, acc} == 9'($past(acc)) + 9'($past(work_reg_n_data))) else $error("register add wrong");
	a_and_reg: assert property (@(posedge clk) disable iff (!resetn)
		state == AAG_IDLE && tick && op_valid && op_byte[7:3] == aag_pkg::OP_AND_REG_HI
		|=> acc == ($past(acc) & $past(work_reg_n_data)) && carry == $past(carry)) else $error("and wrong");
	a_imm_two_cyc: assert property (@(posedge clk) disable iff (!resetn)
		state == AAG_IDLE && tick && op_valid && op_byte == aag_pkg::OP_ADD_IMM
		|=> need_imm && !done ##1 (!done)[*1] ##[0:300] done) else $error("immediate form timing wrong");
	a_other_kept: assert property (@(posedge clk) disable iff (!resetn)
		pass_on |-> acc == $past(acc) && carry == $past(carry) && !op_taken) else $error("foreign op changed state");
	// Done is registered, so it shows one clock after the final tick, in the same clock in which the state leaves the wait
	c_imm_add: cover property (@(posedge clk) disable iff (!resetn)
		state == AAG_IMM && tick && op_valid ##1 done);
	c_fixup: cover property (@(posedge clk) disable iff (!resetn)
		state == AAG_IDLE && tick && op_valid && op_byte == aag_pkg::OP_FIXUP);
	c_pass: cover property (@(posedge clk) disable iff (!resetn) pass_on);
endmodule

// ===== common/aag_pkg.sv
// Package: opcodes, widths and timing for the accumulator group
package aag_pkg;
	localparam int DATA_W = 8;
	// Opcodes of the group
	localparam logic [7:0] OP_ADD_IMM = 8'h03;
	localparam logic [7:0] OP_ADD_CARRY_IN_IMM = 8'h13;
	localparam logic [7:0] OP_AND_IMM = 8'h53;
	localparam logic [7:0] OP_INVERT = 8'h37;
	localparam logic [7:0] OP_ZERO = 8'h27;
	localparam logic [7:0] OP_FIXUP = 8'h57;
	localparam logic [7:0] OP_DEC = 8'h07;
	localparam logic [7:0] OP_INC = 8'h17;
	// Upper five bits of register forms, upper seven of pointer forms
	localparam logic [4:0] OP_ADD_REG_HI = 5'h0d;
	localparam logic [4:0] OP_ADD_CARRY_IN_REG_HI = 5'h0f;
	localparam logic [4:0] OP_AND_REG_HI = 5'h0b;
	localparam logic [6:0] OP_ADD_PTR_HI = 7'h30;
	localparam logic [6:0] OP_ADD_CARRY_IN_PTR_HI = 7'h38;
	localparam logic [6:0] OP_AND_PTR_HI = 7'h28;
	// Reset values
	localparam logic [7:0] ACC_RESET = 8'h00;
	// Timing: instruction cycle from a 6 MHz crystal is 2500 ns
	localparam int CLK_PERIOD_NS = 10;
	localparam int INSN_CYCLE_NS = 2500;
	localparam int INSN_CYCLE_CLKS = INSN_CYCLE_NS / CLK_PERIOD_NS;
endpackage

// ===== logic/aag_cycle_div.sv
// Instruction-cycle enable divider
`timescale 1ns/1ps
module aag_cycle_div #(
	parameter int DIV = 250
) (
	input wire logic clk,
	input wire logic resetn,
	output logic tick
);
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic next_tick;

	// The counter is 16 bits wide, so larger divisors cannot be served
	if (DIV < 1 || DIV > 65535) begin : g_bad_div
		$error("aag_cycle_div: DIV out of range");
	end

	always_comb begin
		next_tick = 1'b0;
		next_cnt = cnt + 16'h0001;
		if (cnt == 16'(DIV - 1)) begin
			next_cnt = 16'h0000;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 16'h0000;
			tick <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end
endmodule

// ===== test/tb.sv
// Self-checking bench for the accumulator group with a reference model
`timescale 1ns/1ps
// ==========================================
// Bench top
module tb;
	// Short instruction cycle keeps the run brief
	localparam int CYC = 3;
	logic clk;
	logic resetn;
	logic op_valid;
	logic carry;
	logic aux_carry;
	logic op_taken;
	logic need_imm;
	logic pass_on;
	logic done;
	logic [7:0] op_byte;
	logic [7:0] work_reg_n_data;
	logic [7:0] indirect_via_pointer_data;
	logic [7:0] acc;
	logic [7:0] pass_op;
	logic [2:0] work_reg_n_sel;
	int err_total = 0;
	int n_tests = 0;
	int seed = 92079;
	int cycles = 0;
	int a, c, ac, t;

	aag_core #(.CYCLE_CLKS(CYC)) i_aag_core (.clk(clk), .resetn(resetn), .op_byte(op_byte), .op_valid(op_valid),
		.work_reg_n_data(work_reg_n_data), .indirect_via_pointer_data(indirect_via_pointer_data),
		.work_reg_n_sel(work_reg_n_sel), .acc(acc), .carry(carry), .aux_carry(aux_carry), .op_taken(op_taken),
		.need_imm(need_imm), .pass_on(pass_on), .pass_op(pass_op), .done(done));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Hang guard, well above the expected length of the run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			err_total++;
			conclude();
		end
	end

	// ==========================================
	// Reference model and checks
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic bit is_imm(input logic [7:0] o);
		return o inside {aag_pkg::OP_ADD_IMM, aag_pkg::OP_ADD_CARRY_IN_IMM, aag_pkg::OP_AND_IMM};
	endfunction

	function automatic bit in_grp(input logic [7:0] o);
		return is_imm(o) || o inside {aag_pkg::OP_INVERT, aag_pkg::OP_ZERO, aag_pkg::OP_FIXUP, aag_pkg::OP_DEC,
			aag_pkg::OP_INC}
			|| o[7:3] inside {aag_pkg::OP_ADD_REG_HI, aag_pkg::OP_ADD_CARRY_IN_REG_HI, aag_pkg::OP_AND_REG_HI}
			|| o[7:1] inside {aag_pkg::OP_ADD_PTR_HI, aag_pkg::OP_ADD_CARRY_IN_PTR_HI, aag_pkg::OP_AND_PTR_HI};
	endfunction

	task automatic add(input int x, input int cin);
		ac = ((a % 16) + (x % 16) + cin) > 15;
		t = a + x + cin;
		c = t > 255;
		a = t % 256;
	endtask

	task automatic model(input logic [7:0] o, input int x);
		if (o == aag_pkg::OP_ADD_IMM || o[7:3] == aag_pkg::OP_ADD_REG_HI || o[7:1] == aag_pkg::OP_ADD_PTR_HI) begin
			add(x, 0);
		end else if (o == aag_pkg::OP_ADD_CARRY_IN_IMM || o[7:3] == aag_pkg::OP_ADD_CARRY_IN_REG_HI
			|| o[7:1] == aag_pkg::OP_ADD_CARRY_IN_PTR_HI) begin
			add(x, c);
		end else if (o == aag_pkg::OP_AND_IMM || o[7:3] == aag_pkg::OP_AND_REG_HI || o[7:1] == aag_pkg::OP_AND_PTR_HI) begin
			a = a & x;
		end else if (o == aag_pkg::OP_INVERT) begin
			a = 255 - a;
		end else if (o == aag_pkg::OP_ZERO) begin
			a = 0;
		end else if (o == aag_pkg::OP_FIXUP) begin
			// Carry is only ever set here, never cleared
			t = ((a % 16) > 9 || ac) ? a + 6 : a;
			if (t > 255) c = 1;
			t = t % 256;
			if (t / 16 > 9 || c) t = t + 8'h60;
			if (t > 255) c = 1;
			a = t % 256;
		end else if (o == aag_pkg::OP_DEC) begin
			a = (a + 255) % 256;
		end else if (o == aag_pkg::OP_INC) begin
			a = (a + 1) % 256;
		end
	endtask

	// ==========================================
	// One instruction: present, wait for the answer, compare
	task automatic exec(input logic [7:0] o);
		logic [7:0] imm, rd, pd;
		int w;
		imm = 8'($random(seed));
		rd = 8'($random(seed));
		pd = 8'($random(seed));
		w = 0;
		@(posedge clk);
		op_byte <= o;
		op_valid <= 1'b1;
		work_reg_n_data <= rd;
		indirect_via_pointer_data <= pd;
		do begin
			@(posedge clk);
			#1;
			w++;
		end while (op_taken !== 1'b1 && pass_on !== 1'b1 && w < 20);
		chk("op_taken", 8'(in_grp(o)), {7'h0, op_taken});
		chk("work_reg_n_sel", {5'h00, o[2:0]}, {5'h00, work_reg_n_sel});
		if (!in_grp(o)) begin
			chk("pass_on", 8'h01, {7'h0, pass_on});
			chk("pass_op", o, pass_op);
			chk("done foreign", 8'h00, {7'h0, done});
		end else if (is_imm(o)) begin
			chk("need_imm", 8'h01, {7'h0, need_imm});
			w = 0;
			do begin
				@(posedge clk);
				if (w == 0) op_byte <= imm;
				#1;
				w++;
			end while (done !== 1'b1 && w < 20);
			chk("imm cycles", 8'(CYC), 8'(w));
			chk("need_imm end", 8'h00, {7'h0, need_imm});
		end else begin
			chk("done", 8'h01, {7'h0, done});
		end
		model(o, is_imm(o) ? imm : (o[3] ? rd : pd));
		chk("acc", 8'(a), acc);
		chk("carry", 8'(c), {7'h0, carry});
		chk("aux_carry", 8'(ac), {7'h0, aux_carry});
	endtask

	task automatic conclude();
		$display("Checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================
	// Main sequence: every opcode once, a reset mid-run, then random opcodes
	initial begin
		resetn = 1'b0;
		op_byte = 8'h00;
		op_valid = 1'b0;
		work_reg_n_data = 8'h00;
		indirect_via_pointer_data = 8'h00;
		a = 0;
		c = 0;
		ac = 0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 256; i++) exec(8'(i));
		// Valid low across several ticks: nothing may be taken or change
		@(posedge clk);
		op_valid <= 1'b0;
		repeat (3 * CYC) begin
			@(posedge clk);
			#1;
			chk("idle pulses", 8'h00, {5'h00, done, op_taken, pass_on});
			chk("idle acc", 8'(a), acc);
		end
		// Held byte would re-execute, so drop valid before the reset
		@(posedge clk);
		op_valid <= 1'b0;
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("acc reset", aag_pkg::ACC_RESET, acc);
		chk("flags reset", 8'h00, {6'h0, carry, aux_carry});
		a = 0;
		c = 0;
		ac = 0;
		@(posedge clk);
		resetn <= 1'b1;
		repeat (300) exec(8'($random(seed)));
		conclude();
	end
endmodule
